/* File: src/rxcfg_regs.vh */
// Register map, field positions, reset values and timing counts
// Assumes includers define no macros with the RXCFG_ prefix
//
// How it works
// R1 - Guard unit select 0: each guard step is 16 carrier periods
// R2 - Guard unit select 1: each guard step is half a data bit
// R3 - After transmit end, receiver inputs ignored for guard field steps
// R4 - Upper nibble of threshold register sets decoder minimum level
// R5 - Lower nibble of threshold register sets phase detector minimum level
// R6 - Input register bit 7: 0 fully differential, 1 single pin
// R7 - Input register bit 6: 0 normal converter, 1 card detect mode
// R8 - Bits 5..4 pick signal source: idle, analog, envelope, generic
// R9 - Collision flagged only at 1/8, 1/4 or 1/2 of signal strength
// R10 - Collision threshold code 3 switches collision detection off
// R11 - Software writes zero to analog register trim bits 7..6
// R12 - Analog register bits 3..2 select one of four high-pass corners
// R13 - Analog register bits 1..0 select one of four gain settings
// R14 - Reserved bits of input and analog registers read zero
`ifndef RXCFG_REGS_VH
`define RXCFG_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RXCFG_ADDR_GUARD      8'h36
`define RXCFG_ADDR_THRESH     8'h37
`define RXCFG_ADDR_INPUT      8'h38
`define RXCFG_ADDR_ANALOG     8'h39

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RXCFG_RST_GUARD       8'h00
`define RXCFG_RST_THRESH      8'h00
`define RXCFG_RST_INPUT       8'h00
`define RXCFG_RST_ANALOG      8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RXCFG_GUARD_UNIT_BIT  7
`define RXCFG_GUARD_MSB       6
`define RXCFG_GUARD_LSB       0
`define RXCFG_DEC_MSB         7
`define RXCFG_DEC_LSB         4
`define RXCFG_PHASE_MSB       3
`define RXCFG_PHASE_LSB       0
`define RXCFG_SINGLE_BIT      7
`define RXCFG_CONV_BIT        6
`define RXCFG_SRC_MSB         5
`define RXCFG_SRC_LSB         4
`define RXCFG_COLL_MSB        1
`define RXCFG_COLL_LSB        0
`define RXCFG_TRIM_MSB        7
`define RXCFG_TRIM_LSB        6
`define RXCFG_HPCF_MSB        3
`define RXCFG_HPCF_LSB        2
`define RXCFG_GAIN_MSB        1
`define RXCFG_GAIN_LSB        0
`define RXCFG_INPUT_WMASK     8'hf3
`define RXCFG_ANALOG_WMASK    8'hcf

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define RXCFG_SRC_IDLE        2'h0
`define RXCFG_SRC_ANALOG      2'h1
`define RXCFG_SRC_ENVELOPE    2'h2
`define RXCFG_SRC_GENERIC     2'h3
`define RXCFG_COLL_EIGHTH     2'h0
`define RXCFG_COLL_QUARTER    2'h1
`define RXCFG_COLL_HALF       2'h2
`define RXCFG_COLL_OFF        2'h3
`define RXCFG_BAUD_106        3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RXCFG_SYS_KHZ         20000
`define RXCFG_CARRIER_KHZ     13560
`define RXCFG_CARR_PER_STEP   16
`define RXCFG_HALF_BIT_106    64

`endif

/* File: src/rxcfg_guard_timer.v */
// Guard countdown after a transmission ends
// Assumes start and unit length come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module rxcfg_guard_timer (
	input  wire       i_clk_sys,
	input  wire       i_arst_n,
	input  wire       i_start,
	input  wire [6:0] i_steps,
	input  wire [7:0] i_unit_cycles,
	output wire       o_active
);

	// ------------------------------------------------------------
	// Step and unit counters
	// ------------------------------------------------------------
	reg  [6:0] steps_left;
	reg  [7:0] unit_left;
	wire       unit_done;

	assign unit_done = (unit_left == 8'h01);
	assign o_active  = (steps_left != 7'h00);

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			steps_left <= 7'h00;
			unit_left  <= 8'h00;
		end else if (i_start) begin
			steps_left <= i_steps; // R3
			unit_left  <= i_unit_cycles;
		end else if (o_active) begin
			if (unit_done) begin
				steps_left <= steps_left - 7'h01;
				unit_left  <= i_unit_cycles;
			end else begin
				unit_left  <= unit_left - 8'h01;
			end
		end
	end

endmodule // rxcfg_guard_timer

`default_nettype wire

/* File: src/rxcfg_top.v */
// Receiver configuration registers and the logic they steer
// Assumes register port and receive strobes run on i_clk_sys
`timescale 1ns/100ps
`default_nettype none
`include "rxcfg_regs.vh"

module rxcfg_top (
	input  wire       i_clk_sys,
	input  wire       i_arst_n,
	input  wire [7:0] i_reg_addr,
	input  wire [7:0] i_reg_wdata,
	input  wire       i_reg_wr,
	input  wire       i_reg_rd,
	output reg  [7:0] o_reg_rdata,
	input  wire       i_tx_end,
	input  wire [2:0] i_rx_baud,
	input  wire       i_rx_valid,
	output wire       o_rx_valid,
	output wire       o_guard_active,
	input  wire [3:0] i_dec_level,
	input  wire       i_dec_valid,
	output reg        o_dec_valid,
	input  wire [3:0] i_phase_level,
	input  wire       i_phase_valid,
	output reg        o_phase_valid,
	input  wire [7:0] i_sig_strength,
	input  wire [7:0] i_coll_strength,
	input  wire       i_coll_sample,
	output reg        o_collision,
	output reg  [3:0] o_decoder_min_threshold,
	output reg  [3:0] o_phase_min_threshold,
	output reg        o_rx_single_input,
	output reg        o_converter_op_mode,
	output reg  [3:0] o_signal_source_sel,
	output reg  [1:0] o_collision_threshold,
	output reg  [1:0] o_midref_trim,
	output reg  [1:0] o_hpf_corner_sel,
	output reg  [1:0] o_gain_sel
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Carrier periods to system cycles, rounded up
	function [7:0] carr_to_cycles;
		input [7:0] carriers;
		reg   [31:0] prod;
		begin
			prod = carriers * `RXCFG_SYS_KHZ + `RXCFG_CARRIER_KHZ - 1;
			prod = prod / `RXCFG_CARRIER_KHZ;
			carr_to_cycles = prod[7:0];
		end
	endfunction

	// One-hot source route from a source code
	function [3:0] src_onehot;
		input [1:0] code;
		begin
			case (code)
				`RXCFG_SRC_IDLE:     src_onehot = 4'h1;
				`RXCFG_SRC_ANALOG:   src_onehot = 4'h2;
				`RXCFG_SRC_ENVELOPE: src_onehot = 4'h4;
				`RXCFG_SRC_GENERIC:  src_onehot = 4'h8;
				default:             src_onehot = 4'h1;
			endcase
		end
	endfunction

	// True when level reaches the minimum
	function at_least;
		input [3:0] level;
		input [3:0] minimum;
		begin
			at_least = (level >= minimum);
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg  [7:0] rx_guard_time_cfg;
	reg  [7:0] decoder_threshold_cfg;
	reg  [7:0] receiver_input_cfg;
	reg  [7:0] analog_frontend_cfg;
	reg  [7:0] next_rdata;

	wire wr_guard;
	wire wr_thresh;
	wire wr_input;
	wire wr_analog;

	assign wr_guard  = i_reg_wr && (i_reg_addr == `RXCFG_ADDR_GUARD);
	assign wr_thresh = i_reg_wr && (i_reg_addr == `RXCFG_ADDR_THRESH);
	assign wr_input  = i_reg_wr && (i_reg_addr == `RXCFG_ADDR_INPUT);
	assign wr_analog = i_reg_wr && (i_reg_addr == `RXCFG_ADDR_ANALOG);

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_guard_time_cfg     <= `RXCFG_RST_GUARD;
			decoder_threshold_cfg <= `RXCFG_RST_THRESH;
			receiver_input_cfg    <= `RXCFG_RST_INPUT;
			analog_frontend_cfg   <= `RXCFG_RST_ANALOG;
		end else begin
			if (wr_guard) begin
				rx_guard_time_cfg <= i_reg_wdata;
			end
			if (wr_thresh) begin
				decoder_threshold_cfg <= i_reg_wdata;
			end
			if (wr_input) begin
				receiver_input_cfg <= i_reg_wdata & `RXCFG_INPUT_WMASK; // R14
			end
			if (wr_analog) begin
				analog_frontend_cfg <= i_reg_wdata & `RXCFG_ANALOG_WMASK; // R14
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always @* begin
		case (i_reg_addr)
			`RXCFG_ADDR_GUARD:  next_rdata = rx_guard_time_cfg;
			`RXCFG_ADDR_THRESH: next_rdata = decoder_threshold_cfg;
			`RXCFG_ADDR_INPUT:  next_rdata = receiver_input_cfg;
			`RXCFG_ADDR_ANALOG: next_rdata = analog_frontend_cfg;
			default:            next_rdata = 8'h00;
		endcase
	end

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Guard unit length
	// ------------------------------------------------------------
	wire       guard_unit_sel;
	wire [6:0] guard_time_field;
	reg  [7:0] half_bit_carriers;
	reg  [7:0] unit_cycles;

	assign guard_unit_sel   = rx_guard_time_cfg[`RXCFG_GUARD_UNIT_BIT];
	assign guard_time_field =
		rx_guard_time_cfg[`RXCFG_GUARD_MSB:`RXCFG_GUARD_LSB];

	// Half bit halves with each doubling of bit rate
	always @* begin
		case (i_rx_baud)
			3'h4:    half_bit_carriers = 8'h40;
			3'h5:    half_bit_carriers = 8'h20;
			3'h6:    half_bit_carriers = 8'h10;
			3'h7:    half_bit_carriers = 8'h08;
			default: half_bit_carriers = 8'h40;
		endcase
	end

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			unit_cycles <= 8'h18;
		end else if (guard_unit_sel) begin
			unit_cycles <= carr_to_cycles(half_bit_carriers); // R2
		end else begin
			unit_cycles <= carr_to_cycles(8'h10); // R1
		end
	end

	// ------------------------------------------------------------
	// Guard after transmit
	// ------------------------------------------------------------
	rxcfg_guard_timer u_guard (
		.i_clk_sys     (i_clk_sys),
		.i_arst_n      (i_arst_n),
		.i_start       (i_tx_end),
		.i_steps       (guard_time_field),
		.i_unit_cycles (unit_cycles),
		.o_active      (o_guard_active)
	);

	assign o_rx_valid = i_rx_valid && !o_guard_active; // R3

	// ------------------------------------------------------------
	// Decoder and phase thresholds
	// ------------------------------------------------------------
	wire [3:0] dec_min;
	wire [3:0] phase_min;

	assign dec_min   = decoder_threshold_cfg[`RXCFG_DEC_MSB:`RXCFG_DEC_LSB];
	assign phase_min =
		decoder_threshold_cfg[`RXCFG_PHASE_MSB:`RXCFG_PHASE_LSB];

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_dec_valid   <= 1'b0;
			o_phase_valid <= 1'b0;
		end else begin
			o_dec_valid   <= i_dec_valid && !o_guard_active &&
				at_least(i_dec_level, dec_min); // R4
			o_phase_valid <= i_phase_valid && !o_guard_active &&
				at_least(i_phase_level, phase_min); // R5
		end
	end

	// ------------------------------------------------------------
	// Collision detection
	// ------------------------------------------------------------
	wire [1:0]  coll_code;
	reg  [10:0] coll_scaled;
	reg         coll_hit;

	assign coll_code = receiver_input_cfg[`RXCFG_COLL_MSB:`RXCFG_COLL_LSB];

	// Collision times 8, 4 or 2 compared against the signal
	always @* begin
		coll_hit = 1'b0;
		case (coll_code)
			`RXCFG_COLL_EIGHTH: begin
				coll_scaled = {i_coll_strength, 3'h0}; // R9
				coll_hit    = coll_scaled >= {3'h0, i_sig_strength};
			end
			`RXCFG_COLL_QUARTER: begin
				coll_scaled = {1'b0, i_coll_strength, 2'h0}; // R9
				coll_hit    = coll_scaled >= {3'h0, i_sig_strength};
			end
			`RXCFG_COLL_HALF: begin
				coll_scaled = {2'h0, i_coll_strength, 1'b0}; // R9
				coll_hit    = coll_scaled >= {3'h0, i_sig_strength};
			end
			`RXCFG_COLL_OFF: begin
				coll_scaled = 11'h000;
				coll_hit    = 1'b0; // R10
			end
			default: begin
				coll_scaled = 11'h000;
				coll_hit    = 1'b0;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_collision <= 1'b0;
		end else begin
			o_collision <= i_coll_sample && !o_guard_active && coll_hit;
		end
	end

	// ------------------------------------------------------------
	// Static configuration outputs
	// ------------------------------------------------------------
	always @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_decoder_min_threshold <= 4'h0;
			o_phase_min_threshold   <= 4'h0;
			o_rx_single_input       <= 1'b0;
			o_converter_op_mode     <= 1'b0;
			o_signal_source_sel     <= 4'h1;
			o_collision_threshold   <= 2'h0;
			o_midref_trim           <= 2'h0;
			o_hpf_corner_sel        <= 2'h0;
			o_gain_sel              <= 2'h0;
		end else begin
			o_decoder_min_threshold <= dec_min; // R4
			o_phase_min_threshold   <= phase_min; // R5
			o_rx_single_input       <=
				receiver_input_cfg[`RXCFG_SINGLE_BIT]; // R6
			o_converter_op_mode     <=
				receiver_input_cfg[`RXCFG_CONV_BIT]; // R7
			o_signal_source_sel     <= src_onehot(
				receiver_input_cfg[`RXCFG_SRC_MSB:`RXCFG_SRC_LSB]); // R8
			o_collision_threshold   <= coll_code;
			o_midref_trim           <=
				analog_frontend_cfg[`RXCFG_TRIM_MSB:`RXCFG_TRIM_LSB];
			o_hpf_corner_sel        <=
				analog_frontend_cfg[`RXCFG_HPCF_MSB:`RXCFG_HPCF_LSB]; // R12
			o_gain_sel              <=
				analog_frontend_cfg[`RXCFG_GAIN_MSB:`RXCFG_GAIN_LSB]; // R13
		end
	end

endmodule // rxcfg_top

`default_nettype wire

/* File: tb/rxcfg_host_model.sv */
// Host side write data path for the receiver configuration registers
// Assumes the bench hands it address and data of each write
`timescale 1ns/100ps
`default_nettype none
module rxcfg_host_model (
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_wdata
);
	// Trim bits always written as zero
	assign o_wdata = (i_addr == 8'h39) ? {2'h0, i_wdata[5:0]} : i_wdata;
endmodule // rxcfg_host_model
`default_nettype wire

/* File: tb/rxcfg_chk.sv */
// Port assertions of the receiver configuration block
// Assumes a single clock domain, bound to rxcfg_top
`timescale 1ns/100ps
`default_nettype none
module rxcfg_chk (
	input wire logic       i_clk_sys,
	input wire logic       i_arst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic       i_reg_wr,
	input wire logic       i_tx_end,
	input wire logic       i_rx_valid,
	input wire logic       o_rx_valid,
	input wire logic       o_guard_active,
	input wire logic [3:0] i_dec_level,
	input wire logic       i_dec_valid,
	input wire logic       o_dec_valid,
	input wire logic [7:0] i_sig_strength,
	input wire logic [7:0] i_coll_strength,
	input wire logic       i_coll_sample,
	input wire logic       o_collision,
	input wire logic [3:0] o_decoder_min_threshold,
	input wire logic [3:0] o_phase_min_threshold,
	input wire logic [3:0] o_signal_source_sel,
	input wire logic [1:0] o_collision_threshold,
	input wire logic [1:0] o_midref_trim,
	input wire logic [1:0] o_hpf_corner_sel,
	input wire logic [1:0] o_gain_sel
);
	wire [10:0] coll_scaled;
	assign coll_scaled =
		{3'h0, i_coll_strength} << (2'h3 - o_collision_threshold);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	sequence s_wr(a);
		i_reg_wr && i_reg_addr == a;
	endsequence
	a_rx_gate: assert property (i_rx_valid && o_guard_active |-> !o_rx_valid)
		else $error("receive strobe passed during guard");
	a_guard_start: assert property ($rose(o_guard_active) |-> $past(i_tx_end))
		else $error("guard began without transmit end");
	a_dec_pass: assert property (i_dec_valid && !o_guard_active &&
		i_dec_level >= o_decoder_min_threshold |=> o_dec_valid)
		else $error("decoder strobe lost");
	a_dec_only: assert property (o_dec_valid |-> $past(i_dec_valid) &&
		$past(i_dec_level) >= $past(o_decoder_min_threshold))
		else $error("decoder strobe without cause");
	a_coll_hit: assert property (i_coll_sample && !o_guard_active &&
		o_collision_threshold != 2'h3 && coll_scaled >= {3'h0, i_sig_strength}
		|=> o_collision) else $error("collision missed");
	a_coll_off: assert property (o_collision |-> $past(i_coll_sample) &&
		$past(o_collision_threshold) != 2'h3) else $error("collision while off");
	a_guard_mute: assert property (o_dec_valid || o_collision |->
		!$past(o_guard_active)) else $error("strobe passed during guard");
	a_src_cfg: assert property (s_wr(8'h38) |-> ##2
		o_signal_source_sel == 4'h1 << $past(i_reg_wdata[5:4], 2) &&
		o_collision_threshold == $past(i_reg_wdata[1:0], 2))
		else $error("input register fields wrong");
	a_ana_cfg: assert property (s_wr(8'h39) |-> ##2
		{o_midref_trim, o_hpf_corner_sel, o_gain_sel} ==
		{$past(i_reg_wdata[7:6], 2), $past(i_reg_wdata[3:0], 2)})
		else $error("analog register fields wrong");
	a_thr_cfg: assert property (s_wr(8'h37) |-> ##2
		{o_decoder_min_threshold, o_phase_min_threshold} ==
		$past(i_reg_wdata, 2)) else $error("threshold fields wrong");
endmodule // rxcfg_chk
bind rxcfg_top rxcfg_chk u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_tx_end(i_tx_end), .i_rx_valid(i_rx_valid), .o_rx_valid(o_rx_valid),
	.o_guard_active(o_guard_active), .i_dec_level(i_dec_level),
	.i_dec_valid(i_dec_valid), .o_dec_valid(o_dec_valid),
	.i_sig_strength(i_sig_strength), .i_coll_strength(i_coll_strength),
	.i_coll_sample(i_coll_sample), .o_collision(o_collision),
	.o_decoder_min_threshold(o_decoder_min_threshold),
	.o_phase_min_threshold(o_phase_min_threshold),
	.o_signal_source_sel(o_signal_source_sel),
	.o_collision_threshold(o_collision_threshold),
	.o_midref_trim(o_midref_trim), .o_hpf_corner_sel(o_hpf_corner_sel),
	.o_gain_sel(o_gain_sel));
`default_nettype wire

/* File: tb/tb.sv */
// Register and strobe tests of the receiver configuration block
// Assumes rxcfg_top on one 20 MHz clock with the host model on write data
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
	$display("FAIL %0t %h %h", $time, (a), (b)); end end
module tb;
	logic       clk = 1'b0, arst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic       tx_end = 1'b0, rx_v = 1'b0, dec_v = 1'b0, ph_v = 1'b0;
	logic       coll_s = 1'b0, r, g_prev;
	logic [7:0] sig = 8'h40;
	logic [7:0] addr = 8'h00, wdata = 8'h00, m_wdata, rdata, d, a, coll = 8'h00;
	logic [3:0] lvl = 4'h0, dmin, pmin, src;
	logic [2:0] baud = 3'h4;
	logic [1:0] cthr, trim, hpf, gain;
	logic       o_rxv, guard, dec_o, ph_o, coll_o, single, conv;
	int         i, n, cycles = 0, mismatches = 0, checks_done = 0;
	logic [7:0] g_cfg[6] = '{8'h02, 8'h81, 8'h83, 8'h82, 8'h81, 8'h00};
	logic [2:0] g_baud[6] = '{3'h4, 3'h4, 3'h5, 3'h6, 3'h7, 3'h4};
	int         g_n[6] = '{48, 95, 144, 48, 12, 0};
	always #25 clk = ~clk;
	rxcfg_host_model u_host (.i_addr(addr), .i_wdata(wdata), .o_wdata(m_wdata));
	rxcfg_top dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_reg_addr(addr),
		.i_reg_wdata(m_wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
		.o_reg_rdata(rdata), .i_tx_end(tx_end), .i_rx_baud(baud),
		.i_rx_valid(rx_v), .o_rx_valid(o_rxv), .o_guard_active(guard),
		.i_dec_level(lvl), .i_dec_valid(dec_v), .o_dec_valid(dec_o),
		.i_phase_level(lvl), .i_phase_valid(ph_v), .o_phase_valid(ph_o),
		.i_sig_strength(sig), .i_coll_strength(coll), .i_coll_sample(coll_s),
		.o_collision(coll_o), .o_decoder_min_threshold(dmin),
		.o_phase_min_threshold(pmin), .o_rx_single_input(single),
		.o_converter_op_mode(conv), .o_signal_source_sel(src),
		.o_collision_threshold(cthr), .o_midref_trim(trim),
		.o_hpf_corner_sel(hpf), .o_gain_sel(gain));
	task wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clk) begin addr <= ad; wdata <= dt; wr_s <= 1'b1; end
		@(posedge clk) wr_s <= 1'b0;
		@(posedge clk) #1;
	endtask
	task rd(input logic [7:0] ad, output logic [7:0] dt);
		@(posedge clk) begin addr <= ad; rd_s <= 1'b1; end
		@(posedge clk) rd_s <= 1'b0;
		#1 dt = rdata;
	endtask
	task pulse(input int k, input logic [7:0] v, output logic q);
		@(posedge clk) begin
			lvl <= v[3:0]; coll <= v;
			dec_v <= (k == 0); ph_v <= (k == 1); coll_s <= (k == 2);
		end
		@(posedge clk) begin dec_v <= 1'b0; ph_v <= 1'b0; coll_s <= 1'b0; end
		#1 q = (k == 0) ? dec_o : (k == 1) ? ph_o : coll_o;
	endtask
	task results;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin mismatches++; results; end
	end
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rx_v <= 1'b1;
		for (a = 8'h36; a < 8'h3b; a++) begin rd(a, d); `CHK(d, 8'h00) end
		`CHK(src, 4'h1)
		wr(8'h36, 8'ha5); rd(8'h36, d); `CHK(d, 8'ha5)
		wr(8'h37, 8'h3c); rd(8'h37, d); `CHK({dmin, pmin}, 8'h3c)
		wr(8'h38, 8'hff); rd(8'h38, d); `CHK(d, 8'hf3)
		wr(8'h39, 8'hff); rd(8'h39, d); `CHK(d, 8'h0f)
		`CHK({trim, hpf}, 4'h3)
		`CHK(gain, 2'h3)
		wr(8'h3a, 8'h55); rd(8'h3a, d); `CHK(d, 8'h00)
		for (i = 0; i < 4; i++) begin
			wr(8'h38, {2'(i), 2'(i), 2'h0, 2'(i)});
			`CHK(single, i[1])
			`CHK(conv, i[0])
			`CHK({src, cthr}, {4'h1 << 2'(i), 2'(i)})
			pulse(2, (i == 3) ? 8'hff : 8'h40 >> (3 - i), r);
			`CHK(r, i != 3)
			pulse(2, (8'h40 >> (3 - i)) - 8'h01, r); `CHK(r, 1'b0)
		end
		wr(8'h38, 8'h02);
		@(posedge clk) sig <= 8'hc8;
		pulse(2, 8'h64, r); `CHK(r, 1'b1)
		pulse(2, 8'h63, r); `CHK(r, 1'b0)
		wr(8'h37, 8'h53);
		pulse(0, 8'h05, r); `CHK(r, 1'b1)
		pulse(0, 8'h04, r); `CHK(r, 1'b0)
		pulse(1, 8'h03, r); `CHK(r, 1'b1)
		pulse(1, 8'h02, r); `CHK(r, 1'b0)
		@(posedge clk) begin
			lvl <= 4'hf; coll <= 8'hff;
			dec_v <= 1'b1; ph_v <= 1'b1; coll_s <= 1'b1;
		end
		for (i = 0; i < 6; i++) begin
			wr(8'h36, g_cfg[i]);
			@(posedge clk) baud <= g_baud[i];
			repeat (3) @(posedge clk);
			tx_end <= 1'b1;
			@(posedge clk) tx_end <= 1'b0;
			n = 0;
			g_prev = 1'b0;
			repeat (160) begin
				#1 if (guard === 1'b1) n++;
				`CHK(o_rxv, guard !== 1'b1)
				`CHK({dec_o, ph_o, coll_o}, {3{g_prev !== 1'b1}})
				g_prev = guard;
				@(posedge clk);
			end
			if (g_cfg[i][7]) `CHK(n, g_n[i])
			else `CHK(n, g_n[i])
		end
		@(posedge clk) arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(8'h37, d); `CHK({d, dmin, src}, 16'h0001)
		results;
	end
endmodule // tb
`default_nettype wire
